// *** include/port_config_regs.vh ***
/*
 Register locations, field positions and reset values for the port block.
 Assumes it is included by bare name from the design file only.
*/
`ifndef PORT_CONFIG_REGS_VH
`define PORT_CONFIG_REGS_VH

// Data memory locations of the port registers.
`define ADDR_L_DATA    8'hd0
`define ADDR_L_CONFIG  8'hd1
`define ADDR_L_PINS    8'hd2
`define ADDR_G_DATA    8'hd4
`define ADDR_G_CONFIG  8'hd5
`define ADDR_G_PINS    8'hd6
`define ADDR_D_DATA    8'hdc
`define ADDR_CAN_CTRL  8'hdd

// Special-purpose bit positions in port G registers.
`define G_DATA_FULLSTOP_BIT  7
`define G_DATA_IDLE_BIT      6
`define G_CFG_ALT_PHASE_BIT  6

// CAN bus control drive enable bit positions.
`define CAN_DRV_A_BIT  0
`define CAN_DRV_B_BIT  1

// Reset values.
`define PORT_RESET_VAL  8'h00
`define D_RESET_VAL     4'hf
`define CAN_RESET_VAL   8'h00

`endif

// *** hdl/port_config_pin_logic.v ***
/*
 Port pin logic of an 8-bit controller: a 7-bit bidirectional port with
 wake-up detection, an 8-bit port with special control bits and a clock
 output, a 4-bit output port, and CAN transmit drive enables.
 Assumes a single-cycle data memory bus from the core on clk_i, and pins
 whose levels come from outside the clock domain.
*/

`timescale 1ns/100ps
`include "port_config_regs.vh"

module port_config_pin_logic (
   // Clock and reset.
   input  wire       clk_i,
   input  wire       rst_b_i,
   // Data memory bus from the core.
   input  wire [7:0] addr_i,
   input  wire       wr_i,
   input  wire       rd_i,
   input  wire [7:0] wdata_i,
   output reg  [7:0] rdata_o,
   // Seven-bit port pins.
   input  wire [6:0] port_l_in_i,
   output wire [6:0] port_l_out_o,
   output wire [6:0] port_l_oe_o,
   output wire [6:0] port_l_pullup_o,
   // Eight-bit port pins, bits 0 to 5 bidirectional, bit 6 input only.
   input  wire [6:0] port_g_in_i,
   output wire [5:0] port_g_out_o,
   output wire [5:0] port_g_oe_o,
   output wire [6:0] port_g_pullup_o,
   // Dedicated clock output pin and its source.
   input  wire       osc_clk_i,
   output wire       oscillator_out_o,
   // Four-bit output-only port.
   output wire [3:0] port_d_o,
   // Peripheral alternate functions on the seven-bit port.
   input  wire       comparator_a_output_i,
   input  wire       comparator_a_en_i,
   input  wire       comparator_b_output_i,
   input  wire       comparator_b_en_i,
   input  wire       pulse_out_a_i,
   input  wire       pulse_out_a_en_i,
   input  wire       pulse_out_b_i,
   input  wire       pulse_out_b_en_i,
   output wire       capture_input_pin_o,
   output wire [6:0] comparator_pins_o,
   // Peripheral alternate functions on the eight-bit port.
   input  wire       serial_data_out_i,
   input  wire       serial_clock_out_i,
   input  wire       serial_master_i,
   input  wire       timer_io_out_i,
   input  wire       timer_io_drive_i,
   output wire       serial_data_in_o,
   output wire       serial_clock_pin_o,
   output wire       timer_io_pin_o,
   output wire       timer_capture_pin_o,
   output wire       ext_irq_pin_o,
   // Mode controls.
   output wire       serial_alt_phase_o,
   output reg        fullstop_req_o,
   output reg        idle_req_o,
   // Wake-up events, one bit per seven-bit port pin.
   output reg  [6:0] multi_pin_wakeup_o,
   // CAN transmit pins.
   input  wire       can_transmit_a_i,
   input  wire       can_transmit_b_i,
   output wire       can_transmit_a_o,
   output wire       can_transmit_a_oe_o,
   output wire       can_transmit_b_o,
   output wire       can_transmit_b_oe_o
);

   reg  [1:0] rst_sync_r;       // Reset release synchroniser.
   wire       rst_b;            // Synchronised reset, active low.
   reg  [7:0] l_data_r;         // Seven-bit port data register.
   reg  [7:0] l_cfg_r;          // Seven-bit port configuration register.
   reg  [7:0] port_g_output_data_r;  // Eight-bit port data register.
   reg  [7:0] port_g_configuration_r;// Eight-bit port configuration.
   reg  [3:0] d_data_r;         // Output-only port data.
   reg  [7:0] can_ctrl_r;       // CAN bus control register.
   reg  [6:0] l_meta_r;         // First synchroniser stage, port L.
   reg  [6:0] l_pin_r;          // Sampled port L levels.
   reg  [6:0] l_prev_r;         // Previous sample for edge detection.
   reg  [6:0] g_meta_r;         // First synchroniser stage, port G.
   reg  [6:0] g_pin_r;          // Sampled port G levels.
   reg  [7:0] rd_nxt;           // Read data mux result.
   reg  [2:0] wake_arm_r;       // Fills with ones after reset.

   // Drive-enable decode of one config/data pair; returns {oe, pullup}.
   // The output enable follows the config bit alone; the data bit means
   // a pull-up only while the pin is an input.
   function [1:0] pin_mode;
      input cfg;
      input dat;
      begin
         pin_mode = {cfg, ~cfg & dat};
      end
   endfunction

   // Release the reset through two flip-flops so every register leaves
   // reset on the same edge.
   always @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         rst_sync_r <= 2'h0;
      end else begin
         rst_sync_r <= {rst_sync_r[0], 1'b1};
      end
   end
   assign rst_b = rst_sync_r[1];

   // Pin inputs cross into the clock domain through two flip-flops; only
   // the second stage is read by any logic.
   always @(posedge clk_i or negedge rst_b) begin
      if (!rst_b) begin
         l_meta_r <= 7'h00;
         l_pin_r  <= 7'h00;
         l_prev_r <= 7'h00;
         g_meta_r <= 7'h00;
         g_pin_r  <= 7'h00;
      end else begin
         l_meta_r <= port_l_in_i;
         l_pin_r  <= l_meta_r;
         l_prev_r <= l_pin_r;
         g_meta_r <= port_g_in_i;
         g_pin_r  <= g_meta_r;
      end
   end

   // Port L has no bit 7, so that bit is always stored as zero.
   // Register writes. The two power-saving requests are one-cycle pulses
   // so that waking up never finds a stale request waiting.
   always @(posedge clk_i or negedge rst_b) begin
      if (!rst_b) begin
         l_data_r               <= `PORT_RESET_VAL;
         l_cfg_r                <= `PORT_RESET_VAL;
         port_g_output_data_r   <= `PORT_RESET_VAL;
         port_g_configuration_r <= `PORT_RESET_VAL;
         d_data_r               <= `D_RESET_VAL;
         can_ctrl_r             <= `CAN_RESET_VAL;
         fullstop_req_o         <= 1'b0;
         idle_req_o             <= 1'b0;
      end else begin
         fullstop_req_o <= 1'b0;
         idle_req_o     <= 1'b0;
         if (wr_i) begin
            case (addr_i)
               `ADDR_L_DATA:   l_data_r <= {1'b0, wdata_i[6:0]};
               `ADDR_L_CONFIG: l_cfg_r  <= {1'b0, wdata_i[6:0]};
               `ADDR_G_DATA: begin
                  port_g_output_data_r <= wdata_i;
                  fullstop_req_o <= wdata_i[`G_DATA_FULLSTOP_BIT];
                  idle_req_o     <= wdata_i[`G_DATA_IDLE_BIT];
               end
               `ADDR_G_CONFIG: port_g_configuration_r <= wdata_i;
               `ADDR_D_DATA:   d_data_r   <= wdata_i[3:0];
               `ADDR_CAN_CTRL: can_ctrl_r <= wdata_i;
               default: ;
            endcase
         end
      end
   end

   // Read mux. Unmapped locations read zero. The port G pin read shows
   // the clock output level in bit 7, so software can see that the
   // oscillator runs.
   always @* begin
      case (addr_i)
         `ADDR_L_DATA:   rd_nxt = l_data_r;
         `ADDR_L_CONFIG: rd_nxt = l_cfg_r;
         `ADDR_L_PINS:   rd_nxt = {1'b0, l_pin_r};
         `ADDR_G_DATA:   rd_nxt = {2'h0, port_g_output_data_r[5:0]};
         `ADDR_G_CONFIG: rd_nxt = port_g_configuration_r;
         `ADDR_G_PINS:   rd_nxt = {oscillator_out_o, g_pin_r};
         `ADDR_D_DATA:   rd_nxt = {4'h0, d_data_r};
         `ADDR_CAN_CTRL: rd_nxt = can_ctrl_r;
         default:        rd_nxt = 8'h00;
      endcase
   end

   // Read data is registered, valid the cycle after the strobe.
   always @(posedge clk_i or negedge rst_b) begin
      if (!rst_b) begin
         rdata_o <= 8'h00;
      end else if (rd_i) begin
         rdata_o <= rd_nxt;
      end
   end

   // Wake-up events: any change on a sampled port L pin raises its bit
   // for one cycle; edge polarity and enables live in the wake-up unit.
   // The edge detector leaves reset at zero while an idle pin often
   // sits high, so reports are held off until both samples are real.
   always @(posedge clk_i or negedge rst_b) begin
      if (!rst_b) begin
         wake_arm_r         <= 3'h0;
         multi_pin_wakeup_o <= 7'h00;
      end else begin
         wake_arm_r         <= {wake_arm_r[1:0], 1'b1};
         multi_pin_wakeup_o <= (l_pin_r ^ l_prev_r)
                               & {7{wake_arm_r[2]}};
      end
   end

   // Port L drivers. Peripheral outputs override the port latch on their
   // pins only while that peripheral is enabled.
   genvar i;
   generate
      for (i = 0; i < 7; i = i + 1) begin : g_l
         wire [1:0] m = pin_mode(l_cfg_r[i], l_data_r[i]);
         assign port_l_pullup_o[i] = m[0];
         if (i == 6) begin : g_alt6
            assign port_l_out_o[i] = comparator_b_en_i ? comparator_b_output_i
                                   : pulse_out_a_en_i ? pulse_out_a_i
                                   : l_data_r[i];
            assign port_l_oe_o[i]  = m[1] | comparator_b_en_i
                                   | pulse_out_a_en_i;
         end else if (i == 5) begin : g_alt5
            assign port_l_out_o[i] = pulse_out_b_en_i ? pulse_out_b_i
                                   : l_data_r[i];
            assign port_l_oe_o[i]  = m[1] | pulse_out_b_en_i;
         end else if (i == 2) begin : g_alt2
            assign port_l_out_o[i] = comparator_a_en_i ? comparator_a_output_i
                                   : l_data_r[i];
            assign port_l_oe_o[i]  = m[1] | comparator_a_en_i;
         end else begin : g_plain
            assign port_l_out_o[i] = l_data_r[i];
            assign port_l_oe_o[i]  = m[1];
         end
      end
   endgenerate

   // Analog inputs are routed straight through; the comparator side
   // picks its own inputs from these pins.
   assign comparator_pins_o   = port_l_in_i;
   assign capture_input_pin_o = l_pin_r[6];

   // Port G drivers, bits 0 to 5; serial clock and timer outputs take over
   // G5 and G3 while active; serial data drives G4 whenever it is an output.
   generate
      for (i = 0; i < 6; i = i + 1) begin : g_g
         wire [1:0] m = pin_mode(port_g_configuration_r[i],
                                 port_g_output_data_r[i]);
         assign port_g_pullup_o[i] = m[0];
         if (i == 5) begin : g_sk
            assign port_g_out_o[i] = serial_master_i ? serial_clock_out_i
                                   : port_g_output_data_r[i];
            assign port_g_oe_o[i]  = m[1] | serial_master_i;
         end else if (i == 4) begin : g_so
            assign port_g_out_o[i] = m[1] ? serial_data_out_i
                                   : port_g_output_data_r[i];
            assign port_g_oe_o[i]  = m[1];
         end else if (i == 3) begin : g_t
            assign port_g_out_o[i] = timer_io_drive_i ? timer_io_out_i
                                   : port_g_output_data_r[i];
            assign port_g_oe_o[i]  = m[1] | timer_io_drive_i;
         end else begin : g_plain
            assign port_g_out_o[i] = port_g_output_data_r[i];
            assign port_g_oe_o[i]  = m[1];
         end
      end
   endgenerate

   // Bit 6 is input only, so it never drives. Its config and data bits
   // are taken by the serial phase and idle controls, so no bit is left
   // to ask for a pull-up and the pull-up stays off.
   assign port_g_pullup_o[6]  = 1'b0;
   assign oscillator_out_o    = osc_clk_i;
   assign serial_data_in_o    = g_pin_r[6];
   assign serial_clock_pin_o  = g_pin_r[5];
   assign timer_io_pin_o      = g_pin_r[3];
   assign timer_capture_pin_o = g_pin_r[2];
   assign ext_irq_pin_o       = g_pin_r[0];
   assign serial_alt_phase_o  =
      port_g_configuration_r[`G_CFG_ALT_PHASE_BIT];

   // Output port forced high straight from the reset pin, so it is high
   // even before the synchroniser releases; all four bits, bit 2 included,
   // are driven high by this block alone.
   assign port_d_o = rst_b_i ? d_data_r : `D_RESET_VAL;

   // CAN transmit pins float until software enables each driver. The
   // enables clear on reset, so a bus already in use is never driven
   // before software has decided to join it.
   assign can_transmit_a_o    = can_transmit_a_i;
   assign can_transmit_a_oe_o = can_ctrl_r[`CAN_DRV_A_BIT];
   assign can_transmit_b_o    = can_transmit_b_i;
   assign can_transmit_b_oe_o = can_ctrl_r[`CAN_DRV_B_BIT];

endmodule // port_config_pin_logic

// *** testbench/port_config_pin_logic_asserts.sv ***
/* Checker for the port block: bus writes, read masking, mode pulses.
   Bound into the top module and sees only its ports. */
`timescale 1ns/100ps
module port_config_pin_logic_asserts (
   input wire       clk_i,
   input wire       rst_b_i,
   input wire [7:0] addr_i,
   input wire       wr_i,
   input wire       rd_i,
   input wire [7:0] wdata_i,
   input wire [7:0] rdata_o,
   input wire [6:0] port_l_oe_o,
   input wire [5:0] port_g_oe_o,
   input wire       serial_alt_phase_o,
   input wire       fullstop_req_o,
   input wire       idle_req_o,
   input wire       can_transmit_a_oe_o,
   input wire       can_transmit_b_oe_o
);
   // One clock domain; the pin reset silences every check.
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_b_i);
   a_l_cfg_drive: assert property (wr_i && addr_i == 8'hd1 |=>
      port_l_oe_o == $past(wdata_i[6:0])) else $error("L drive wrong");
   // G3 may be taken over by the timer, so it is left out.
   a_g_cfg_drive: assert property (wr_i && addr_i == 8'hd5 |=>
      (port_g_oe_o & 6'h37) == ($past(wdata_i[5:0]) & 6'h37))
      else $error("G drive wrong");
   a_stop_pulse: assert property (
      fullstop_req_o == $past(wr_i && addr_i == 8'hd4 && wdata_i[7]))
      else $error("stop pulse wrong");
   a_idle_pulse: assert property (
      idle_req_o == $past(wr_i && addr_i == 8'hd4 && wdata_i[6]))
      else $error("idle pulse wrong");
   a_alt_phase: assert property (wr_i && addr_i == 8'hd5 |=>
      serial_alt_phase_o == $past(wdata_i[6])) else $error("phase wrong");
   a_can_drive: assert property (wr_i && addr_i == 8'hdd |=>
      {can_transmit_b_oe_o, can_transmit_a_oe_o} == $past(wdata_i[1:0]))
      else $error("CAN enable wrong");
   a_g_read_mask: assert property (rd_i && addr_i == 8'hd4 |=>
      rdata_o[7:6] == 2'b00) else $error("G data top bits read");
   a_unmapped_zero: assert property (rd_i && !(addr_i inside
      {8'hd0, 8'hd1, 8'hd2, 8'hd4, 8'hd5, 8'hd6, 8'hdc, 8'hdd}) |=>
      rdata_o == 8'h00) else $error("unmapped read not zero");
endmodule // port_config_pin_logic_asserts

bind port_config_pin_logic port_config_pin_logic_asserts chk (.*);

// *** testbench/pin_world_model.sv ***
/* Outside world of the port pins: device drive, outside drive, pull-up.
   Assumes the bench sets the outside drive just after a clock edge. */
`timescale 1ns/100ps
module pin_world_model (
   input  wire        clk_i,
   input  wire [6:0]  l_out_i,
   input  wire [6:0]  l_oe_i,
   input  wire [6:0]  l_pu_i,
   input  wire [5:0]  g_out_i,
   input  wire [5:0]  g_oe_i,
   input  wire [6:0]  g_pu_i,
   input  wire [13:0] ext_i,
   input  wire [13:0] ext_en_i,
   output wire [6:0]  l_pin_o,
   output wire [6:0]  g_pin_o
);
   wire  [13:0] oe = {1'b0, g_oe_i, l_oe_i};  // G6 is never driven.
   wire  [13:0] dv = {1'b0, g_out_i, l_out_i};
   wire  [13:0] pu = {g_pu_i, l_pu_i};
   wire  [13:0] dr = oe | ext_en_i;           // Someone drives the pin.
   logic [13:0] last_r = 14'h0000;            // Last driven level.
   wire  [13:0] lvl;
   // A floating pin with no pull-up shows the inverse of its last level,
   // so a design that reads it cannot pass by luck.
   assign lvl = oe & dv | ~oe & (ext_en_i & ext_i |
                ~ext_en_i & (pu | ~last_r));
   always @(posedge clk_i) begin
      last_r <= dr & lvl | ~dr & last_r;
   end
   assign l_pin_o = lvl[6:0];
   assign g_pin_o = lvl[13:7];
endmodule // pin_world_model

// *** testbench/tb_port_config_pin_logic.sv ***
/* Self-checking bench for the port block with a pin world model.
   Assumes one clock; peripheral takeovers stay off outside their test, except the timer drive of G3. */
`timescale 1ns/100ps
module tb_port_config_pin_logic;
   logic clk_i, rst_b_i, wr_i, rd_i, osc_clk_i, comparator_a_output_i;
   logic comparator_a_en_i, comparator_b_output_i, comparator_b_en_i;
   logic pulse_out_a_i, pulse_out_a_en_i, pulse_out_b_i, pulse_out_b_en_i;
   logic serial_data_out_i, serial_clock_out_i, serial_master_i;
   logic timer_io_out_i, timer_io_drive_i, can_transmit_a_i;
   logic can_transmit_b_i, capture_input_pin_o, serial_data_in_o;
   logic serial_clock_pin_o, timer_io_pin_o, timer_capture_pin_o;
   logic ext_irq_pin_o, oscillator_out_o, serial_alt_phase_o;
   logic fullstop_req_o, idle_req_o, can_transmit_a_o, can_transmit_b_o;
   logic can_transmit_a_oe_o, can_transmit_b_oe_o;
   logic [7:0]  addr_i, wdata_i, rdata_o, lc, ld, gc, gd, got;
   logic [6:0]  port_l_in_i, port_l_out_o, port_l_oe_o, port_l_pullup_o;
   logic [6:0]  port_g_in_i, port_g_pullup_o, comparator_pins_o;
   logic [6:0]  multi_pin_wakeup_o, kl, kg, lp, gp, gcm, gdm;
   logic [5:0]  port_g_out_o, port_g_oe_o;
   logic [3:0]  port_d_o;
   logic [13:0] ext_r, ext_en_r;  // Outside drive, G above L.
   int          n_mismatch = 0;
   int          n_compared = 0;

   port_config_pin_logic DUT (.*);
   pin_world_model pins (.clk_i(clk_i), .l_out_i(port_l_out_o),
      .l_oe_i(port_l_oe_o), .l_pu_i(port_l_pullup_o),
      .g_out_i(port_g_out_o), .g_oe_i(port_g_oe_o),
      .g_pu_i(port_g_pullup_o), .ext_i(ext_r), .ext_en_i(ext_en_r),
      .l_pin_o(port_l_in_i), .g_pin_o(port_g_in_i));

   // The 50 MHz core clock.
   initial begin
      clk_i = 1'b0;
      forever #10 clk_i = ~clk_i;
   end

   task chk(input string n, input logic [7:0] e, g);
      n_compared++;
      if (g !== e) begin
         n_mismatch++;
         $display("BAD %s expected %h seen %h", n, e, g);
      end
   endtask

   // Expected pin level: own drive, else the outside, else pull-up high;
   // bits that nobody sets are masked by the caller.
   function automatic logic [6:0] pin_lvl(input logic [6:0] c, d, x, xe);
      return c & d | ~c & (x | ~xe);
   endfunction

   // One bus cycle, write or read; read data lands in got.
   task bus(input logic w, input logic [7:0] a, d);
      @(posedge clk_i);
      {wr_i, rd_i, addr_i, wdata_i} <= {w, !w, a, d};
      @(posedge clk_i);
      {wr_i, rd_i} <= 2'b00;
      #1 got = rdata_o;
   endtask

   task rdc(input string n, input logic [7:0] a, e, m);
      bus(1'b0, a, 8'h00);
      chk(n, e & m, got & m);
   endtask

   task do_reset;
      @(posedge clk_i);
      rst_b_i <= 1'b0;
      repeat (10) @(posedge clk_i);
      chk("d_rst", 8'h0f, {4'h0, port_d_o});
      chk("pin_rst", 8'h00, {1'b0, port_l_oe_o | port_l_pullup_o});
      rst_b_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      rdc("l_cfg", 8'hd1, 8'h00, 8'hff);
      rdc("g_dat", 8'hd4, 8'h00, 8'hff);
   endtask

   task end_sim;
      $display("compared %0d mismatched %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   // Cut a hang short well past the expected run of about 700 cycles.
   initial begin
      repeat (20000) @(posedge clk_i);
      n_mismatch++;
      end_sim;
   end

   initial begin
      {rst_b_i, wr_i, rd_i, addr_i, wdata_i, ext_r, ext_en_r} = '0;
      {osc_clk_i, comparator_a_output_i, comparator_b_output_i} = '0;
      {pulse_out_a_i, pulse_out_b_i, serial_data_out_i} = '0;
      {serial_clock_out_i, timer_io_out_i, timer_io_drive_i} = '0;
      {can_transmit_a_i, can_transmit_b_i, serial_master_i} = '0;
      {comparator_a_en_i, comparator_b_en_i} = '0;
      {pulse_out_a_en_i, pulse_out_b_en_i} = '0;
      got = 8'($urandom(47));
      do_reset;
      for (int k = 0; k < 24; k++) begin
         {lc, ld, gc, gd} = $urandom;
         if (k < 2) gd[7:6] = 2'b11;  // Both modes requested at once.
         bus(1'b1, 8'hd1, lc);
         bus(1'b1, 8'hd0, ld);
         bus(1'b1, 8'hd5, gc);
         bus(1'b1, 8'hd4, gd);
         chk("stop", {7'h0, gd[7]}, {7'h0, fullstop_req_o});
         chk("idle", {7'h0, gd[6]}, {7'h0, idle_req_o});
         chk("l_oe", lc & 8'h7f, {1'b0, port_l_oe_o});
         chk("l_out", lc & ld & 8'h7f, {1'b0, port_l_out_o & lc[6:0]});
         chk("l_pu", ~lc & ld & 8'h7f, {1'b0, port_l_pullup_o});
         chk("g_out", gc & gd & 8'h27,
            {2'h0, port_g_out_o} & gc & 8'h27);
         chk("g_pu", ~gc & gd & 8'h3f, {1'b0, port_g_pullup_o});
         chk("phase", {7'h0, gc[6]}, {7'h0, serial_alt_phase_o});
         @(posedge clk_i);
         {ext_r, ext_en_r} <= 28'($urandom);
         {osc_clk_i, serial_data_out_i, timer_io_out_i, timer_io_drive_i,
          can_transmit_a_i, can_transmit_b_i} <= 6'($urandom);
         repeat (3) @(posedge clk_i);
         #1;
         gcm = {1'b0, gc[5:0]};
         gdm = {1'b0, gd[5:0]};
         kl = lc[6:0] | ld[6:0] | ext_en_r[6:0];
         kg = (gcm | gdm | ext_en_r[13:7]) & 7'h67;  // Skip G3 and G4.
         lp = pin_lvl(lc[6:0], ld[6:0], ext_r[6:0], ext_en_r[6:0]);
         gp = pin_lvl(gcm, gdm, ext_r[13:7], ext_en_r[13:7]);
         chk("g_alt", {3'h0, port_g_in_i[6:5], port_g_in_i[3:2],
            port_g_in_i[0]}, {3'h0, serial_data_in_o, serial_clock_pin_o,
            timer_io_pin_o, timer_capture_pin_o, ext_irq_pin_o});
         chk("l_alt", {port_l_in_i[6], port_l_in_i},
            {capture_input_pin_o, comparator_pins_o});
         chk("osc", {7'h0, osc_clk_i}, {7'h0, oscillator_out_o});
         chk("can_tx", {6'h0, can_transmit_b_i, can_transmit_a_i},
            {6'h0, can_transmit_b_o, can_transmit_a_o});
         rdc("l_pins", 8'hd2, {1'b0, lp}, {1'b0, kl});
         rdc("g_pins", 8'hd6, {1'b0, gp}, {1'b0, kg});
         rdc("l_dat", 8'hd0, ld & 8'h7f, 8'hff);
         rdc("g_dat", 8'hd4, gd & 8'h3f, 8'hff);
         rdc("g_cfg", 8'hd5, gc, 8'h7f);
         rdc("hole", 8'hd3, 8'h00, 8'hff);
      end
      // Every L pin, driven from outside, must raise its wake-up flag.
      bus(1'b1, 8'hd1, 8'h00);
      @(posedge clk_i);
      ext_en_r <= 14'h3fff;
      repeat (5) @(posedge clk_i);
      for (int i = 0; i < 7; i++) begin
         @(posedge clk_i);
         ext_r[i] <= ~ext_r[i];
         got = 8'h00;
         repeat (6) begin
            @(posedge clk_i);
            #1 if (multi_pin_wakeup_o === 7'(1 << i)) got = 8'h01;
         end
         chk("wake", 8'h01, got);
      end
      for (int v = 0; v < 4; v++) begin
         bus(1'b1, 8'hdd, 8'(v));
         chk("can_oe", 8'(v), {6'h0, can_transmit_b_oe_o,
            can_transmit_a_oe_o});
      end
      // Peripherals take over L6, L5, L2, G5 and G3 while enabled; only
      // one L6 source at a time, as the two have no stated priority.
      for (int k = 0; k < 9; k++) begin
         @(posedge clk_i);
         {comparator_b_output_i, pulse_out_a_i, pulse_out_b_i,
          comparator_a_output_i, serial_clock_out_i,
          timer_io_out_i} <= 6'($urandom);
         {comparator_b_en_i, pulse_out_a_en_i} <= 2'(k % 3);
         {pulse_out_b_en_i, comparator_a_en_i, serial_master_i,
          timer_io_drive_i} <= 4'hf;
         @(posedge clk_i);
         #1;
         chk("l6_src", {7'h0, comparator_b_en_i ? comparator_b_output_i
            : pulse_out_a_en_i ? pulse_out_a_i : ld[6]},
            {7'h0, port_l_out_o[6]});
         chk("l_take", {3'h0, pulse_out_b_i, comparator_a_output_i,
            k % 3 != 0, 2'h3}, {3'h0, port_l_out_o[5], port_l_out_o[2],
            port_l_oe_o[6], port_l_oe_o[5], port_l_oe_o[2]});
         chk("g_take", {4'h0, serial_clock_out_i, timer_io_out_i, 2'h3},
            {4'h0, port_g_out_o[5], port_g_out_o[3], port_g_oe_o[5],
            port_g_oe_o[3]});
      end
      @(posedge clk_i);
      {comparator_b_en_i, pulse_out_a_en_i, pulse_out_b_en_i,
       comparator_a_en_i, serial_master_i, timer_io_drive_i} <= '0;
      bus(1'b1, 8'hdc, 8'h0a);
      chk("port_d", 8'h0a, {4'h0, port_d_o});
      do_reset;
      end_sim;
   end
endmodule // tb_port_config_pin_logic
